// >>> pwc_pwm_top.sv
// pwm counter with extension, registers and interrupt
//
// Summary of operation
// - Control bits 7:6 pick the counter clock: /64, /8, /2 or /1.
// - Duty data reloads on extension wrap if bit 4 is 0, else on base wrap.
// - Writing 1 to the clear bit zeroes the counter; writing 0 does not.
// - The clear bit keeps its written value and never self-clears.
// - The counter halts while the run bit is 0 and resumes when it is 1.
// - The overflow interrupt is raised only while its enable bit is 1.
// - Reading the pending bit returns 1 while an overflow is pending.
// - Writing 0 to the pending bit clears it; writing 1 leaves it.
// - Extension register bits 7:2 give the extension in 6+6 and 8+6.
// - In 6+2 mode extension register bits 7:2 are ignored.
// - Mode 00 takes base from duty bits 7:2 and extension from 1:0.
// - Mode 01 takes base from high-res duty 5:0, six-bit extension.
// - Mode 11 takes base from all high-res duty bits, six-bit extension.
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
`include "pwc_regs.svh"
module pwc_pwm_top (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [7:0] bus_addr_i,
  input  wire logic [7:0] bus_wdata_i,
  input  wire logic       bus_wr_i,
  input  wire logic       bus_rd_i,
  output logic      [7:0] bus_rdata_o,
  output logic            pwm_o,
  output logic            irq_o
);

  pwc_pkg::pwc_ctrl_type ctl;
  pwc_pkg::pwc_duty_type split;
  pwc_pkg::pwc_duty_type act;
  pwc_pkg::pwc_res_type  res_mode;
  logic [7:0]            ext_reg;
  logic [7:0]            duty_low;
  logic [7:0]            duty_high;
  logic [7:0]            irq_status;
  logic [7:0]            irq_mask;
  logic [7:0]            cnt;
  logic [5:0]            ext_cnt;
  logic [7:0]            base_cnt;
  logic [7:0]            base_max;
  logic [5:0]            ext_max;
  logic                  tick;
  logic                  step;
  logic                  ovf8;
  logic                  base_wrap;
  logic                  ext_wrap;
  logic                  reload_ev;
  logic                  wr_ctl;
  logic                  clr_pulse;
  logic                  next_pwm;
  logic [7:0]            next_rdata;
  logic [7:0]            irq_set;

  assign wr_ctl    = bus_wr_i && (bus_addr_i == `PWC_OFF_CONTROL);
  // clearing acts on the write itself, not the stored level
  assign clr_pulse = wr_ctl && bus_wdata_i[`PWC_CTL_CLR_BIT];
  assign res_mode  = pwc_pkg::pwc_res_type'(ext_reg[1:0]);

  pwc_prescaler u_pre (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .sel_i     (ctl.clk_sel),
    .tick_o    (tick)
  );

  // upper six extension bits feed the split
  pwc_duty_split u_split (
    .mode_i      (res_mode),
    .duty_low_i  (duty_low),
    .duty_high_i (duty_high),
    .ext_bits_i  (ext_reg[7:2]),
    .duty_o      (split)
  );

  // control register, bit 5 always stored as zero
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      ctl.clk_sel    <= pwc_pkg::PWC_DIV64;
      ctl.unused     <= 1'b0;
      ctl.reload_sel <= 1'b0;
      ctl.clr        <= 1'b0;
      ctl.run        <= 1'b0;
      ctl.ie         <= 1'b0;
    end
    else if (wr_ctl)
    begin
      ctl.clk_sel    <= pwc_pkg::pwc_clk_sel_type'(bus_wdata_i[7:6]);
      ctl.unused     <= 1'b0;
      ctl.reload_sel <= bus_wdata_i[`PWC_CTL_RSEL_BIT];
      ctl.clr        <= bus_wdata_i[`PWC_CTL_CLR_BIT];
      ctl.run        <= bus_wdata_i[`PWC_CTL_RUN_BIT];
      ctl.ie         <= bus_wdata_i[`PWC_CTL_IE_BIT];
    end
  end

  // write 0 clears, overflow in same cycle wins
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      ctl.pend <= 1'b0;
    else if (ovf8)
      ctl.pend <= 1'b1;
    else if (wr_ctl && !bus_wdata_i[`PWC_CTL_PEND_BIT])
      ctl.pend <= 1'b0;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      ext_reg   <= `PWC_RST_EXTENSION;
      duty_low  <= `PWC_RST_DUTY;
      duty_high <= `PWC_RST_DUTY;
      irq_mask  <= `PWC_RST_IRQ;
    end
    else if (bus_wr_i)
    begin
      unique case (bus_addr_i)
        `PWC_OFF_EXTENSION: ext_reg   <= bus_wdata_i;
        `PWC_OFF_DUTY_LOW:  duty_low  <= bus_wdata_i;
        `PWC_OFF_DUTY_HIGH: duty_high <= bus_wdata_i;
        `PWC_OFF_IRQ_MASK:
          irq_mask <= bus_wdata_i & `PWC_IRQ_MASK_BITS;
        default:
        begin
        end
      endcase
    end
  end

  // counter stepping and wrap detection
  assign step     = tick && ctl.run;
  assign base_max = split.base8 ? `PWC_BASE8_MAX : `PWC_BASE6_MAX;
  assign ext_max  = split.ext6 ? `PWC_EXT6_MAX : `PWC_EXT2_MAX;
  assign base_cnt = cnt & base_max;
  // full 8-bit wrap is the overflow event
  assign ovf8      = step && (cnt == `PWC_BASE8_MAX);
  assign base_wrap = step && (base_cnt == base_max);
  assign ext_wrap  = base_wrap && ((ext_cnt & ext_max) == ext_max);
  assign reload_ev = ctl.reload_sel ? base_wrap : ext_wrap;

  // clear on write, hold while stopped
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i || clr_pulse)
    begin
      cnt     <= 8'h00;
      ext_cnt <= 6'h00;
    end
    else if (step)
    begin
      cnt <= cnt + 8'h01;
      if (base_wrap)
        ext_cnt <= (ext_cnt + 6'h01) & ext_max;
    end
  end

  // active duty only changes on reload, avoiding mid-period glitches
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      act <= '0;
    else if (reload_ev)
      act <= split;
  end

  // extension stretches one base step in the first ext slots
  always_comb
  begin
    next_pwm = (base_cnt < act.base) ||
               ((base_cnt == act.base) && (ext_cnt < act.ext));
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      pwm_o <= 1'b0;
    else
      pwm_o <= next_pwm;
  end

  // sticky status, write one to clear, event wins over clear
  assign irq_set = {6'h00, reload_ev, ovf8 && ctl.ie};

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      irq_status <= `PWC_RST_IRQ;
    else if (bus_wr_i && (bus_addr_i == `PWC_OFF_IRQ_STATUS))
      irq_status <= (irq_status & ~bus_wdata_i) | irq_set;
    else
      irq_status <= irq_status | irq_set;
  end

  // overflow reaches the line only when enabled
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      irq_o <= 1'b0;
    else
      irq_o <= (ctl.pend && ctl.ie) ||
               ((irq_status[`PWC_IRQ_OVF_BIT] && ctl.ie &&
                 irq_mask[`PWC_IRQ_OVF_BIT]) ||
                (irq_status[`PWC_IRQ_RELOAD_BIT] &&
                 irq_mask[`PWC_IRQ_RELOAD_BIT]));
  end

  always_comb
  begin
    next_rdata = 8'h00;
    if (bus_rd_i)
    begin
      unique case (bus_addr_i)
        `PWC_OFF_CONTROL:    next_rdata = ctl & `PWC_CTL_UNUSED_MASK;
        `PWC_OFF_EXTENSION:  next_rdata = ext_reg;
        `PWC_OFF_DUTY_LOW:   next_rdata = duty_low;
        `PWC_OFF_DUTY_HIGH:  next_rdata = duty_high;
        `PWC_OFF_IRQ_STATUS: next_rdata = irq_status;
        `PWC_OFF_IRQ_MASK:   next_rdata = irq_mask;
        default:             next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      bus_rdata_o <= 8'h00;
    else
      bus_rdata_o <= next_rdata;
  end

  // checks
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_slow_run;
    tick && ctl.clk_sel == pwc_pkg::PWC_DIV64 && !wr_ctl
    ##1 (ctl.clk_sel == pwc_pkg::PWC_DIV64 && !wr_ctl) [*7];
  endsequence

  sequence s_clear_write;
    bus_wr_i && bus_addr_i == `PWC_OFF_CONTROL
      && bus_wdata_i[`PWC_CTL_CLR_BIT];
  endsequence

  chk_div64_quiet: assert property (s_slow_run |-> !tick)
    else $error("divide by 64 ticked too early");

  chk_div1_every: assert property (
    ctl.clk_sel == pwc_pkg::PWC_DIV1 |-> tick)
    else $error("divide by 1 missed a tick");

  chk_reload_source: assert property (
    !reload_ev |=> act == $past(act))
    else $error("duty changed without reload");

  chk_clear_zeroes: assert property (
    s_clear_write |=> cnt == 8'h00 && ext_cnt == 6'h00)
    else $error("counter not cleared by write");

  chk_clear_sticky: assert property (
    ctl.clr && !wr_ctl |=> ctl.clr)
    else $error("clear bit returned to zero");

  chk_halt_holds: assert property (
    !ctl.run && !clr_pulse |=> $stable(cnt) && $stable(ext_cnt))
    else $error("counter moved while stopped");

  chk_irq_enable: assert property (
    irq_o && !irq_status[`PWC_IRQ_RELOAD_BIT] |-> $past(ctl.ie))
    else $error("interrupt without enable");

  chk_pend_read: assert property (
    bus_rd_i && bus_addr_i == `PWC_OFF_CONTROL
      |=> bus_rdata_o[0] == $past(ctl.pend))
    else $error("pending read mismatch");

  chk_pend_clear: assert property (
    wr_ctl && !bus_wdata_i[0] && !ovf8 |=> !ctl.pend)
    else $error("pending not cleared");

  chk_ovf_sets: assert property (
    ovf8 |=> ctl.pend ##1 (ctl.pend || $past(wr_ctl)))
    else $error("overflow did not set pending");

endmodule

// >>> pwc_regs.svh
// register offsets, field positions and reset values of the pwm block
`ifndef PWC_REGS_SVH
`define PWC_REGS_SVH

`define PWC_OFF_EXTENSION   8'hF1
`define PWC_OFF_CONTROL     8'hF3
`define PWC_OFF_DUTY_LOW    8'hF4
`define PWC_OFF_DUTY_HIGH   8'hF5
`define PWC_OFF_IRQ_STATUS  8'hF6
`define PWC_OFF_IRQ_MASK    8'hF7

`define PWC_CTL_PEND_BIT    0
`define PWC_CTL_IE_BIT      1
`define PWC_CTL_RUN_BIT     2
`define PWC_CTL_CLR_BIT     3
`define PWC_CTL_RSEL_BIT    4
`define PWC_CTL_UNUSED_MASK 8'hDF

`define PWC_IRQ_OVF_BIT     0
`define PWC_IRQ_RELOAD_BIT  1
`define PWC_IRQ_MASK_BITS   8'h03

`define PWC_RST_CONTROL     8'h00
`define PWC_RST_EXTENSION   8'h00
`define PWC_RST_DUTY        8'h00
`define PWC_RST_IRQ         8'h00

`define PWC_PRE_DIV64_MAX   6'h3F
`define PWC_PRE_DIV8_MAX    6'h07
`define PWC_PRE_DIV2_MAX    6'h01
`define PWC_BASE6_MAX       8'h3F
`define PWC_BASE8_MAX       8'hFF
`define PWC_EXT6_MAX        6'h3F
`define PWC_EXT2_MAX        6'h03

`endif

// >>> pwc_pkg.sv
// types shared by the pwm block
package pwc_pkg;

  typedef enum logic [1:0] {
    PWC_DIV64 = 2'b00,
    PWC_DIV8  = 2'b01,
    PWC_DIV2  = 2'b10,
    PWC_DIV1  = 2'b11
  } pwc_clk_sel_type;

  typedef enum logic [1:0] {
    PWC_RES_6_2 = 2'b00,
    PWC_RES_6_6 = 2'b01,
    PWC_RES_ALT = 2'b10,
    PWC_RES_8_6 = 2'b11
  } pwc_res_type;

  typedef struct packed {
    pwc_clk_sel_type clk_sel;
    logic            unused;
    logic            reload_sel;
    logic            clr;
    logic            run;
    logic            ie;
    logic            pend;
  } pwc_ctrl_type;

  typedef struct packed {
    logic [7:0] base;
    logic [5:0] ext;
    logic       base8;
    logic       ext6;
  } pwc_duty_type;

endpackage

// >>> pwc_prescaler.sv
// input clock divider for the pwm counter
`timescale 1ns/1ps
module pwc_prescaler (
  input  wire logic                     sys_clk_i,
  input  wire logic                     rst_n_i,
  input  wire pwc_pkg::pwc_clk_sel_type sel_i,
  output logic                          tick_o
);

  logic [5:0] div_cnt;

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      div_cnt <= 6'h00;
    else
      div_cnt <= div_cnt + 6'h01;
  end

  always_comb
  begin
    unique case (sel_i)
      pwc_pkg::PWC_DIV64: tick_o = (div_cnt == `PWC_PRE_DIV64_MAX);
      pwc_pkg::PWC_DIV8:
        tick_o = ((div_cnt & `PWC_PRE_DIV8_MAX) == `PWC_PRE_DIV8_MAX);
      pwc_pkg::PWC_DIV2:
        tick_o = ((div_cnt & `PWC_PRE_DIV2_MAX) == `PWC_PRE_DIV2_MAX);
      pwc_pkg::PWC_DIV1:  tick_o = 1'b1;
    endcase
  end

endmodule

// >>> pwc_duty_split.sv
// splits duty data into base and extension by resolution mode
`timescale 1ns/1ps
module pwc_duty_split (
  input  wire pwc_pkg::pwc_res_type  mode_i,
  input  wire logic [7:0]            duty_low_i,
  input  wire logic [7:0]            duty_high_i,
  input  wire logic [5:0]            ext_bits_i,
  output pwc_pkg::pwc_duty_type      duty_o
);

  always_comb
  begin
    duty_o = '0;
    unique case (mode_i)
      // low six bits plus six extension
      pwc_pkg::PWC_RES_6_6:
      begin
        duty_o.base = {2'b00, duty_high_i[5:0]};
        duty_o.ext  = ext_bits_i;
        duty_o.ext6 = 1'b1;
      end
      pwc_pkg::PWC_RES_8_6:
      begin
        duty_o.base  = duty_high_i;
        duty_o.ext   = ext_bits_i;
        duty_o.base8 = 1'b1;
        duty_o.ext6  = 1'b1;
      end
      // six plus two, extension reg unused
      pwc_pkg::PWC_RES_6_2, pwc_pkg::PWC_RES_ALT:
      begin
        duty_o.base = {2'b00, duty_low_i[7:2]};
        duty_o.ext  = {4'h0, duty_low_i[1:0]};
      end
    endcase
  end

endmodule

// >>> pwc_load_model.sv
// load on the pwm pin: totals the cycles the pin is driven high
`timescale 1ns/1ps
module pwc_load_model (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        pwm_i,
  output logic      [31:0] high_total_o
);
  // unknown counts as low, so x never inflates the duty
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      high_total_o <= 32'h0000_0000;
    else if (pwm_i === 1'b1)
      high_total_o <= high_total_o + 32'h0000_0001;
  end
endmodule

// >>> tb_top.sv
// self-checking bench for the pwm block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
  miscompares++; $display("unexpected %s exp %0h got %0h", nm, ex, got); \
  end end
module tb_top;
  logic        sys_clk_i   = 1'b0;
  logic        rst_n_i     = 1'b0;
  logic [7:0]  bus_addr_i  = 8'h00;
  logic [7:0]  bus_wdata_i = 8'h00;
  logic        bus_wr_i    = 1'b0;
  logic        bus_rd_i    = 1'b0;
  logic [7:0]  bus_rdata_o;
  logic        pwm_o;
  logic        irq_o;
  logic [31:0] high_total;
  logic        rd_d        = 1'b0;
  logic [7:0]  exp_q[$];
  logic [31:0] seed        = 32'd14;
  int          miscompares = 0;
  int          n_checks    = 0;
  int          cycles      = 0;
  // duty table: extension reg, low duty, high duty, window, high cycles
  logic [7:0]  t_ex[5] = '{8'h00, 8'hFE, 8'hFC, 8'h15, 8'h17};
  logic [7:0]  t_lo[5] = '{8'h41, 8'h41, 8'h41, 8'h00, 8'h00};
  logic [7:0]  t_hi[5] = '{8'h00, 8'h00, 8'h00, 8'hD0, 8'h80};
  int          t_w[5]  = '{256, 256, 256, 4096, 16384};
  logic [31:0] t_e[5]  = '{32'd65, 32'd65, 32'd65, 32'd1029, 32'd8197};

  always #2 sys_clk_i = ~sys_clk_i;

  pwc_pwm_top u_dut (
    .sys_clk_i   (sys_clk_i),
    .rst_n_i     (rst_n_i),
    .bus_addr_i  (bus_addr_i),
    .bus_wdata_i (bus_wdata_i),
    .bus_wr_i    (bus_wr_i),
    .bus_rd_i    (bus_rd_i),
    .bus_rdata_o (bus_rdata_o),
    .pwm_o       (pwm_o),
    .irq_o       (irq_o)
  );

  pwc_load_model u_load (
    .sys_clk_i    (sys_clk_i),
    .rst_n_i      (rst_n_i),
    .pwm_i        (pwm_o),
    .high_total_o (high_total)
  );

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic tally_and_finish();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    bus_addr_i  <= a;
    bus_wdata_i <= d;
    bus_wr_i    <= 1'b1;
    @(posedge sys_clk_i);
    bus_wr_i    <= 1'b0;
  endtask

  // expected value queued now, compared when the data stands
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge sys_clk_i);
    bus_addr_i <= a;
    bus_rd_i   <= 1'b1;
    @(posedge sys_clk_i);
    bus_rd_i   <= 1'b0;
  endtask

  task automatic wait_irq(input int lim, output int n);
    repeat (3) @(posedge sys_clk_i);
    #1;
    n = 3;
    while (irq_o !== 1'b1 && n < lim)
    begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
  endtask

  always @(posedge sys_clk_i)
  begin
    rd_d <= bus_rd_i;
    if (rd_d && exp_q.size() > 0)
      `CHK("read_data", exp_q.pop_front(), bus_rdata_o)
  end

  // hang guard, well above the expected run length
  always @(posedge sys_clk_i)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      miscompares++;
      tally_and_finish();
    end
  end

  initial
  begin
    int          d;
    int          n;
    logic [31:0] h0;
    logic [31:0] h1;
    repeat (10) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    rd(8'hF3, 8'h00);
    rd(8'hF1, 8'h00);
    rd(8'h10, 8'h00);
    seed = xs(seed);
    wr(8'hF1, seed[7:0]);
    rd(8'hF1, seed[7:0]);
    $display("test regs done");
    for (int s = 0; s < 4; s++)
    begin
      d = (s == 0) ? 64 : (s == 1) ? 8 : (s == 2) ? 2 : 1;
      // clear, run, enable; bit 5 kept 0
      wr(8'hF3, {s[1:0], 6'b001110});
      wait_irq(20000, n);
      `CHK("ovf_cycles", 1'b1, n >= 255*d+1 && n <= 256*d+5)
      rd(8'hF3, {s[1:0], 6'b001111});
    end
    $display("test prescale done");
    wr(8'hF3, 8'hCF);
    rd(8'hF3, 8'hCF);
    `CHK("irq_set", 1'b1, irq_o)
    wr(8'hF3, 8'hCA);
    repeat (600) @(posedge sys_clk_i);
    #1;
    `CHK("irq_clear", 1'b0, irq_o)
    rd(8'hF3, 8'hCA);
    wr(8'hF3, 8'hC6);
    wait_irq(300, n);
    `CHK("irq_resume", 1'b1, irq_o)
    wr(8'hF3, 8'hD4);
    repeat (300) @(posedge sys_clk_i);
    #1;
    `CHK("irq_masked", 1'b0, irq_o)
    rd(8'hF3, 8'hD5);
    $display("test irq done");
    for (int i = 0; i < 5; i++)
    begin
      wr(8'hF4, t_lo[i]);
      wr(8'hF5, t_hi[i]);
      wr(8'hF1, t_ex[i]);
      wr(8'hF3, 8'hDC);
      repeat (600) @(posedge sys_clk_i);
      #1;
      h0 = high_total;
      repeat (t_w[i]) @(posedge sys_clk_i);
      #1;
      h1 = high_total;
      `CHK("high_cycles", t_e[i], h1 - h0)
      if (i == 3)
      begin
        // reload on extension wrap: old duty holds for the first 1024
        wr(8'hF5, 8'h08);
        wr(8'hF3, 8'hCC);
        repeat (4) @(posedge sys_clk_i);
        #1;
        h0 = high_total;
        repeat (1024) @(posedge sys_clk_i);
        #1;
        h1 = high_total - h0;
        `CHK("reload_hold", 1'b1, h1 >= 256 && h1 <= 261)
      end
    end
    $display("test duty done");
    repeat (4) @(posedge sys_clk_i);
    tally_and_finish();
  end
endmodule
